// *** hw/coe_map.svh ***
// Register offsets, field positions, reset values and timing counts of the condition evaluator.
// Operation
// - Operand one word offset 0 to 255.
// - Operand one bit 0-15, bit conditions only.
// - Operand two area codes 0-6 or constant.
// - Operand two word offset 0 to 255.
// - Operand two bit 0-15, bit conditions only.
// - Timer setting 0 to 1000, 10 ms steps.
// - Counter setting 0 to 10000 iterations.
// - Constant holds any signed 32-bit value.
// - Data operands compared as signed 32-bit.
// - Top bit set means negative operand.
// - ON true when bit set, OFF when clear.
// - Data comparison true when relation holds.
// - Timer true after configured wait elapses.
// - Counter decrements per reference, reloads at zero.
`ifndef COE_MAP_SVH
`define COE_MAP_SVH
`define COE_A_CTRL 8'h00
`define COE_A_SRC1 8'h04
`define COE_A_SRC2 8'h08
`define COE_A_TIMER 8'h0c
`define COE_A_COUNT 8'h10
`define COE_A_CONST 8'h14
`define COE_A_STAT 8'h18
`define COE_F_COND 3:0
`define COE_F_EVAL 4
`define COE_F_AREA 3:0
`define COE_F_OFF 15:8
`define COE_F_BIT 19:16
`define COE_F_TIMER 9:0
`define COE_F_COUNT 13:0
`define COE_S_BUSY 0
`define COE_S_DONE 1
`define COE_S_TRUE 2
`define COE_S_ERR 3
`define COE_S_REM 29:16
`define COE_AREA_MAX 4'h6
`define COE_AREA_CONST 4'hf
`define COE_TIMER_MAX 10'h3e8
`define COE_COUNT_MAX 14'h2710
`define COE_RST_WORD 32'h0000_0000
`define COE_TICK_MS 10
`define COE_CLK_NS 10
`define COE_C_ON 4'h0
`define COE_C_OFF 4'h1
`define COE_C_AND 4'h2
`define COE_C_OR 4'h3
`define COE_C_EQ 4'h4
`define COE_C_NE 4'h5
`define COE_C_GT 4'h6
`define COE_C_GE 4'h7
`define COE_C_LT 4'h8
`define COE_C_LE 4'h9
`define COE_C_TIMER 4'ha
`define COE_C_COUNT 4'hb
`endif

// *** hw/coe_pkg.sv ***
// Types and field helpers shared by the condition evaluator modules.
`include "coe_map.svh"
package coe_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_FETCH1, ST_FETCH2, ST_JUDGE, ST_WAIT} coe_state_t;
	typedef enum logic [1:0] {F_IDLE, F_LO, F_HI, F_LAST} coe_fstate_t;
	typedef logic [31:0] coe_word_t;
	// Field extraction from an operand source register.
	function automatic logic [3:0] coe_area(input coe_word_t w);
		return w[`COE_F_AREA];
	endfunction
	function automatic logic [7:0] coe_off(input coe_word_t w);
		return w[`COE_F_OFF];
	endfunction
	function automatic logic [3:0] coe_bit(input coe_word_t w);
		return w[`COE_F_BIT];
	endfunction
	// An area code outside 0..6 that is not the constant code is illegal.
	function automatic logic coe_bad_area(input coe_word_t w);
		return (coe_area(w) > `COE_AREA_MAX) && (coe_area(w) != `COE_AREA_CONST);
	endfunction
endpackage

// *** hw/coe_fetch_if.sv ***
// Request and answer between the evaluator and its two-word operand fetcher.
`timescale 1ns/1ps
interface coe_fetch_if;
	logic req;
	logic [2:0] area;
	logic [7:0] offset;
	logic done;
	logic [31:0] data;
	modport host (output req, output area, output offset, input done, input data);
	modport unit (input req, input area, input offset, output done, output data);
endinterface

// *** hw/coe_fetch.sv ***
// Two-word operand fetcher reading the shared memory areas.
`timescale 1ns/1ps
`include "coe_map.svh"
module coe_fetch
	import coe_pkg::*;
(
	// Clock and reset.
	input wire logic clock_i,
	input wire logic arst_n_i,
	// Request side.
	coe_fetch_if.unit fif,
	// Shared memory read port, data valid the cycle after a read.
	output logic mem_rd_o,
	output logic [2:0] mem_area_o,
	output logic [8:0] mem_word_o,
	input wire logic [15:0] mem_rdata_i
);
	coe_fstate_t st_reg;
	logic [15:0] lo_reg;
	logic [31:0] data_reg;
	logic done_reg;

	assign fif.done = done_reg;
	assign fif.data = data_reg;

	// First word is the low half; the second word sits one above, so offset 255 reads 256.
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_reg <= F_IDLE;
			lo_reg <= 16'h0000;
			data_reg <= `COE_RST_WORD;
			done_reg <= 1'b0;
			mem_rd_o <= 1'b0;
			mem_area_o <= 3'h0;
			mem_word_o <= 9'h000;
		end else begin
			done_reg <= 1'b0;
			case (st_reg)
				F_IDLE: begin
					if (fif.req) begin
						mem_rd_o <= 1'b1;
						mem_area_o <= fif.area;
						mem_word_o <= {1'b0, fif.offset};
						st_reg <= F_LO;
					end
				end
				F_LO: begin
					mem_word_o <= 9'(mem_word_o + 9'h001);
					st_reg <= F_HI;
				end
				F_HI: begin
					lo_reg <= mem_rdata_i;
					mem_rd_o <= 1'b0;
					st_reg <= F_LAST;
				end
				F_LAST: begin
					data_reg <= {mem_rdata_i, lo_reg};
					done_reg <= 1'b1;
					st_reg <= F_IDLE;
				end
				default: st_reg <= F_IDLE;
			endcase
		end
	end
endmodule // coe_fetch

// *** hw/coe_top.sv ***
// Condition evaluator: operand selection, timer, counter and judgement behind an AHB-Lite slave.
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "coe_map.svh"
module coe_top
	import coe_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `COE_TICK_MS * 1000000 / `COE_CLK_NS
)
(
	// Clock and reset.
	input wire logic clock_i,
	input wire logic arst_n_i,
	// AHB-Lite slave.
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Shared memory read port.
	output logic mem_rd_o,
	output logic [2:0] mem_area_o,
	output logic [8:0] mem_word_o,
	input wire logic [15:0] mem_rdata_i,
	// Judgement result.
	output logic cond_done_o,
	output logic cond_true_o
);
	localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES - 1);

	coe_fetch_if fif ();

	coe_state_t st_reg;
	logic [3:0] cond_reg;
	coe_word_t src1_reg, src2_reg, const_reg, op1_reg, op2_reg;
	logic [9:0] timer_set_reg, wait_cnt_reg;
	logic [13:0] count_set_reg, count_rem_reg;
	logic [19:0] tick_cnt_reg;
	logic err_reg, done_reg, true_reg, busy_reg;
	logic [7:0] addr_reg;
	logic wr_pend_reg, rd_pend_reg;
	logic [31:0] hrdata_reg;
	logic hready_reg;
	logic done_pulse_reg;

	// Bus decode. Reads take one wait state so that a read right after a write sees new data.
	wire acc = hsel_i & hready_i & htrans_i[1];
	wire wr_acc = acc & hwrite_i;
	wire rd_acc = acc & ~hwrite_i;
	wire wr_ctrl = wr_pend_reg && (addr_reg == `COE_A_CTRL);
	wire wr_src1 = wr_pend_reg && (addr_reg == `COE_A_SRC1);
	wire wr_src2 = wr_pend_reg && (addr_reg == `COE_A_SRC2);
	wire wr_timer = wr_pend_reg && (addr_reg == `COE_A_TIMER);
	wire wr_count = wr_pend_reg && (addr_reg == `COE_A_COUNT);
	wire wr_const = wr_pend_reg && (addr_reg == `COE_A_CONST);
	wire start = wr_ctrl && hwdata_i[`COE_F_EVAL] && (st_reg == ST_IDLE);
	wire [3:0] new_cond = hwdata_i[`COE_F_COND];

	// Status word shows the evaluator's own state and the counter's remaining value.
	logic [31:0] stat_word;
	always_comb begin
		stat_word = `COE_RST_WORD;
		stat_word[`COE_S_BUSY] = busy_reg;
		stat_word[`COE_S_DONE] = done_reg;
		stat_word[`COE_S_TRUE] = true_reg;
		stat_word[`COE_S_ERR] = err_reg;
		stat_word[`COE_S_REM] = count_rem_reg;
	end

	// Read selection; unmapped offsets read as zero.
	wire [31:0] rd_mux =
		(addr_reg == `COE_A_CTRL) ? {28'h0000000, cond_reg} :
		(addr_reg == `COE_A_SRC1) ? src1_reg :
		(addr_reg == `COE_A_SRC2) ? src2_reg :
		(addr_reg == `COE_A_TIMER) ? {22'h000000, timer_set_reg} :
		(addr_reg == `COE_A_COUNT) ? {18'h00000, count_set_reg} :
		(addr_reg == `COE_A_CONST) ? const_reg :
		(addr_reg == `COE_A_STAT) ? stat_word : `COE_RST_WORD;

	// Operand sources and legality checks.
	wire const1 = coe_area(src1_reg) == `COE_AREA_CONST;
	wire const2 = coe_area(src2_reg) == `COE_AREA_CONST;
	wire is_timer = new_cond == `COE_C_TIMER;
	wire is_count = new_cond == `COE_C_COUNT;
	wire is_cmp = new_cond <= `COE_C_LE;
	wire bad_src = coe_bad_area(src1_reg) | coe_bad_area(src2_reg);
	wire both_const = const1 & const2;
	wire bad_timer = timer_set_reg > `COE_TIMER_MAX;
	wire bad_count = count_set_reg > `COE_COUNT_MAX;
	wire start_err = (is_cmp & (bad_src | both_const)) | (is_timer & bad_timer) |
		(is_count & bad_count) | ~(is_cmp | is_timer | is_count);

	// Counter decrements per reference; zero result is false and reloads the setting.
	wire [13:0] cnt_dec = (count_rem_reg == 14'h0000) ? 14'h0000 : 14'(count_rem_reg - 14'h0001);
	wire cnt_true = cnt_dec != 14'h0000;

	// Fetch requests; a constant operand never touches memory.
	wire f1_ok = const1 | fif.done;
	wire go_data = start & is_cmp & ~start_err;
	assign fif.req = (go_data & ~const1) | ((st_reg == ST_FETCH1) & f1_ok & ~const2);
	// Named fields, since a function result cannot be part-selected directly.
	wire [3:0] area1 = coe_area(src1_reg);
	wire [3:0] area2 = coe_area(src2_reg);
	wire [7:0] off1 = coe_off(src1_reg);
	wire [7:0] off2 = coe_off(src2_reg);
	assign fif.area = (st_reg == ST_IDLE) ? area1[2:0] : area2[2:0];
	assign fif.offset = (st_reg == ST_IDLE) ? off1 : off2;

	coe_fetch u_fetch (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.fif(fif),
		.mem_rd_o(mem_rd_o),
		.mem_area_o(mem_area_o),
		.mem_word_o(mem_word_o),
		.mem_rdata_i(mem_rdata_i)
	);

	// Judgement: bit indices count only for bit conditions, data is signed 32-bit.
	wire bit1 = op1_reg[coe_bit(src1_reg)];
	wire bit2 = op2_reg[coe_bit(src2_reg)];
	wire signed [31:0] sa = $signed(op1_reg);
	wire signed [31:0] sb = $signed(op2_reg);
	logic judge;
	always_comb begin
		case (cond_reg)
			`COE_C_ON: judge = bit1;
			`COE_C_OFF: judge = ~bit1;
			`COE_C_AND: judge = bit1 & bit2;
			`COE_C_OR: judge = bit1 | bit2;
			`COE_C_EQ: judge = sa == sb;
			`COE_C_NE: judge = sa != sb;
			`COE_C_GT: judge = sa > sb;
			`COE_C_GE: judge = sa >= sb;
			`COE_C_LT: judge = sa < sb;
			`COE_C_LE: judge = sa <= sb;
			default: judge = 1'b0;
		endcase
	end

	wire tick = (st_reg == ST_WAIT) && (tick_cnt_reg == TICK_LAST);

	// Bus slave pipeline registers.
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			addr_reg <= 8'h00;
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			hrdata_reg <= `COE_RST_WORD;
			hready_reg <= 1'b1;
		end else begin
			if (acc) begin
				addr_reg <= haddr_i[7:0];
			end
			wr_pend_reg <= wr_acc;
			rd_pend_reg <= rd_acc;
			hready_reg <= ~rd_acc;
			if (rd_pend_reg) begin
				hrdata_reg <= rd_mux;
			end
		end
	end

	// Software settings; everything clears to zero at reset.
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cond_reg <= 4'h0;
			src1_reg <= `COE_RST_WORD;
			src2_reg <= `COE_RST_WORD;
			timer_set_reg <= 10'h000;
			count_set_reg <= 14'h0000;
			const_reg <= `COE_RST_WORD;
		end else begin
			if (wr_ctrl && st_reg == ST_IDLE) begin
				cond_reg <= new_cond;
			end
			if (wr_src1) begin
				src1_reg <= {12'h000, hwdata_i[19:0]};
			end
			if (wr_src2) begin
				src2_reg <= {12'h000, hwdata_i[19:0]};
			end
			if (wr_timer) begin
				timer_set_reg <= hwdata_i[`COE_F_TIMER];
			end
			if (wr_count) begin
				count_set_reg <= hwdata_i[`COE_F_COUNT];
			end
			if (wr_const) begin
				const_reg <= hwdata_i;
			end
		end
	end

	// Counter state: a write to the setting reloads it, a reference counts it down.
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			count_rem_reg <= 14'h0000;
		end else if (wr_count) begin
			count_rem_reg <= hwdata_i[`COE_F_COUNT];
		end else if (start & is_count & ~start_err) begin
			count_rem_reg <= cnt_true ? cnt_dec : count_set_reg;
		end
	end

	// Sequencer. A start clears done; the end of a judgement sets it, and when both fall in one cycle (error, counter, zero timer) the set wins.
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_reg <= ST_IDLE;
			op1_reg <= `COE_RST_WORD;
			op2_reg <= `COE_RST_WORD;
			wait_cnt_reg <= 10'h000;
			tick_cnt_reg <= 20'h00000;
			err_reg <= 1'b0;
			done_reg <= 1'b0;
			true_reg <= 1'b0;
			busy_reg <= 1'b0;
			done_pulse_reg <= 1'b0;
		end else begin
			done_pulse_reg <= 1'b0;
			case (st_reg)
				ST_IDLE: begin
					if (start) begin
						err_reg <= start_err;
						done_reg <= 1'b0;
						if (start_err) begin
							done_reg <= 1'b1;
							true_reg <= 1'b0;
							done_pulse_reg <= 1'b1;
						end else if (is_count) begin
							done_reg <= 1'b1;
							true_reg <= cnt_true;
							done_pulse_reg <= 1'b1;
						end else if (is_timer && timer_set_reg == 10'h000) begin
							done_reg <= 1'b1;
							true_reg <= 1'b1;
							done_pulse_reg <= 1'b1;
						end else if (is_timer) begin
							wait_cnt_reg <= timer_set_reg;
							tick_cnt_reg <= 20'h00000;
							busy_reg <= 1'b1;
							st_reg <= ST_WAIT;
						end else begin
							busy_reg <= 1'b1;
							st_reg <= ST_FETCH1;
						end
					end
				end
				ST_FETCH1: begin
					if (f1_ok) begin
						op1_reg <= const1 ? const_reg : fif.data;
						st_reg <= ST_FETCH2;
					end
				end
				ST_FETCH2: begin
					if (const2 | fif.done) begin
						op2_reg <= const2 ? const_reg : fif.data;
						st_reg <= ST_JUDGE;
					end
				end
				ST_JUDGE: begin
					true_reg <= judge;
					done_reg <= 1'b1;
					done_pulse_reg <= 1'b1;
					busy_reg <= 1'b0;
					st_reg <= ST_IDLE;
				end
				ST_WAIT: begin
					tick_cnt_reg <= tick ? 20'h00000 : 20'(tick_cnt_reg + 20'h00001);
					if (tick) begin
						wait_cnt_reg <= 10'(wait_cnt_reg - 10'h001);
						if (wait_cnt_reg == 10'h001) begin
							true_reg <= 1'b1;
							done_reg <= 1'b1;
							done_pulse_reg <= 1'b1;
							busy_reg <= 1'b0;
							st_reg <= ST_IDLE;
						end
					end
				end
				default: st_reg <= ST_IDLE;
			endcase
		end
	end

	// Outputs straight from flip-flops; the slave always answers OKAY.
	assign hrdata_o = hrdata_reg;
	assign hreadyout_o = hready_reg;
	assign hresp_o = 1'b0;
	assign cond_done_o = done_pulse_reg;
	assign cond_true_o = true_reg;

	// Checks. Cycle count in the wait state, for tying the timer result to its setting.
	logic [31:0] wait_cyc_reg;
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wait_cyc_reg <= 32'h0000_0000;
		end else begin
			wait_cyc_reg <= (st_reg == ST_WAIT) ? 32'(wait_cyc_reg + 32'h0000_0001) : 32'h0000_0000;
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_fetch1_req;
		(st_reg == ST_IDLE) && fif.req;
	endsequence
	sequence s_fetch2_req;
		(st_reg == ST_FETCH1) && fif.req;
	endsequence
	// The last tick of a timer wait; the cycle counter still runs during it.
	sequence s_timer_end;
		(st_reg == ST_WAIT) && tick && wait_cnt_reg == 10'h001;
	endsequence

	op1_word_a: assert property (s_fetch1_req |=>
		mem_rd_o && mem_word_o == {1'b0, $past(off1)})
		else $error("operand one first word address wrong");
	op2_word_a: assert property (s_fetch2_req |=>
		mem_rd_o && mem_word_o == {1'b0, $past(off2)})
		else $error("operand two first word address wrong");
	bit_on_a: assert property ((st_reg == ST_JUDGE) && cond_reg == `COE_C_ON |=>
		cond_true_o == $past(bit1) && cond_done_o)
		else $error("bit one judgement wrong");
	bit_and_a: assert property ((st_reg == ST_JUDGE) && cond_reg == `COE_C_AND |=>
		cond_true_o == ($past(bit1) & $past(bit2)))
		else $error("bit two judgement wrong");
	bit_off_a: assert property ((st_reg == ST_JUDGE) && cond_reg == `COE_C_OFF |=>
		cond_true_o != $past(bit1))
		else $error("off judgement wrong");
	area_check_a: assert property (start && is_cmp &&
		(bad_src || both_const) |=> err_reg && cond_done_o && !cond_true_o)
		else $error("illegal source not flagged");
	timer_range_a: assert property (start && is_timer && bad_timer |=>
		err_reg && st_reg == ST_IDLE)
		else $error("timer setting over range accepted");
	count_range_a: assert property (start && is_count && bad_count |=>
		err_reg && !cond_true_o)
		else $error("count setting over range accepted");
	const_use_a: assert property ((st_reg == ST_FETCH2) && const2 |=>
		op2_reg == $past(const_reg))
		else $error("constant operand not used");
	signed_gt_a: assert property ((st_reg == ST_JUDGE) && cond_reg == `COE_C_GT |=>
		cond_true_o == ($signed($past(op1_reg)) > $signed($past(op2_reg))))
		else $error("signed compare wrong");
	data_lt_a: assert property ((st_reg == ST_JUDGE) && cond_reg == `COE_C_LT
		##1 cond_done_o |-> cond_true_o == ($past(sa) < $past(sb)))
		else $error("data comparison wrong");
	timer_wait_a: assert property (s_timer_end |=>
		cond_done_o && cond_true_o && wait_cyc_reg == 32'(timer_set_reg) * TICK_CYCLES)
		else $error("timer ended wrongly");
	timer_len_a: assert property (s_timer_end |->
		wait_cyc_reg + 32'h0000_0001 == 32'(timer_set_reg) * TICK_CYCLES)
		else $error("timer wait length wrong");
	count_step_a: assert property (start && is_count && !start_err && !wr_count |=>
		count_rem_reg == ($past(cnt_true) ? $past(cnt_dec) : $past(count_set_reg)) &&
		cond_true_o == $past(cnt_true))
		else $error("counter step wrong");
endmodule // coe_top

// *** tb/tb.sv ***
// Self-checking bench for the condition evaluator, driven over its register bus.
`timescale 1ns/1ps
`include "coe_map.svh"
module tb
	import coe_pkg::*;
;
	localparam int TICK = 10;
	logic clock_i = 1'b0;
	logic arst_n_i;
	logic hsel_i;
	logic [31:0] haddr_i;
	logic [1:0] htrans_i;
	logic hwrite_i;
	logic [2:0] hsize_i;
	logic [31:0] hwdata_i;
	logic [31:0] hrdata_o;
	logic hreadyout_o;
	logic hresp_o;
	logic mem_rd_o;
	logic [2:0] mem_area_o;
	logic [8:0] mem_word_o;
	logic [15:0] mem_rdata_i;
	logic cond_done_o;
	logic cond_true_o;
	logic [15:0] mem [0:7][0:511];
	int n_mismatch = 0;
	int num_checks = 0;
	int cyc = 0;

	coe_top #(.TICK_CYCLES(TICK)) uut (
		.clock_i(clock_i), .arst_n_i(arst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
		.hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o), .mem_rd_o(mem_rd_o), .mem_area_o(mem_area_o),
		.mem_word_o(mem_word_o), .mem_rdata_i(mem_rdata_i), .cond_done_o(cond_done_o),
		.cond_true_o(cond_true_o)
	);

	// The clock toggles every half period of 5 ns.
	always #5 clock_i = ~clock_i;

	// Memory answers one cycle after a strobe; idle cycles show a changing pattern, not stale data.
	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mem_rdata_i <= 16'h0000;
		end else begin
			mem_rdata_i <= mem_rd_o ? mem[mem_area_o][mem_word_o] : ~mem_rdata_i;
		end
	end

	// A hung handshake would otherwise stall the run forever.
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 10000) begin
			n_mismatch++;
			close_out();
		end
	end

	task automatic close_out();
		if (n_mismatch == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk_word(input string name, input coe_word_t exp, input coe_word_t got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_bit(input string name, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %b seen %b", name, exp, got);
		end
	endtask

	// One single transfer; each phase is held until ready is sampled high at a rising edge.
	task automatic bus(input logic wr, input logic [7:0] addr, input coe_word_t wd,
		output coe_word_t rd);
		@(posedge clock_i);
		hsel_i <= 1'b1;
		htrans_i <= 2'b10;
		haddr_i <= {24'h000000, addr};
		hwrite_i <= wr;
		do begin
			@(posedge clock_i);
		end while (hreadyout_o !== 1'b1);
		hsel_i <= 1'b0;
		htrans_i <= 2'b00;
		hwdata_i <= wd;
		do begin
			@(posedge clock_i);
		end while (hreadyout_o !== 1'b1);
		rd = hrdata_o;
	endtask

	task automatic wr(input logic [7:0] addr, input coe_word_t wd);
		coe_word_t dummy;
		bus(1'b1, addr, wd, dummy);
	endtask

	task automatic rd_chk(input logic [7:0] addr, input coe_word_t exp, input string name);
		coe_word_t r;
		bus(1'b0, addr, 32'h0000_0000, r);
		chk_word(name, exp, r);
	endtask

	// Start one evaluation and count falling edges until its done pulse.
	task automatic eval(input logic [3:0] cond, output logic res, output int n);
		wr(`COE_A_CTRL, {27'h0000000, 1'b1, cond});
		n = 0;
		do begin
			@(negedge clock_i);
			n++;
		end while (cond_done_o !== 1'b1 && n < 5000);
		// A missing done pulse is a failure, not a result.
		if (cond_done_o !== 1'b1) begin
			n_mismatch++;
			$display("Error done pulse expected 1 seen %b", cond_done_o);
		end
		res = cond_true_o;
	endtask

	// Signed relation that a data comparison code should report.
	function automatic logic rel(input logic [3:0] c, input logic signed [31:0] a,
		input logic signed [31:0] b);
		case (c)
			`COE_C_EQ: return a == b;
			`COE_C_NE: return a != b;
			`COE_C_GT: return a > b;
			`COE_C_GE: return a >= b;
			`COE_C_LT: return a < b;
			default: return a <= b;
		endcase
	endfunction

	initial begin
		logic res;
		int n;
		coe_word_t s1 [3];
		coe_word_t s2 [3];
		coe_word_t av [3];
		coe_word_t bv [3];
		logic [7:0] ea [5];
		coe_word_t evl [5];
		logic [3:0] ec [5];
		coe_word_t evs [5];
		arst_n_i = 1'b0;
		hsel_i = 1'b0;
		haddr_i = 32'h0000_0000;
		htrans_i = 2'b00;
		hwrite_i = 1'b0;
		hsize_i = 3'h2;
		hwdata_i = 32'h0000_0000;
		for (int a = 0; a < 8; a++)
			for (int w = 0; w < 512; w++)
				mem[a][w] = 16'h0000;
		mem[2][5] = 16'h0008;
		mem[4][0] = 16'h7fff;
		mem[5][255] = 16'h8000;
		mem[1][10] = 16'hffff;
		mem[1][11] = 16'hffff;
		mem[3][256] = 16'h8000;
		repeat (8) @(posedge clock_i);
		arst_n_i <= 1'b1;
		// Every setting and the unmapped word after the map read zero out of reset.
		for (int a = 0; a < 32; a += 4) rd_chk(a[7:0], 32'h0000_0000, "reset value");
		chk_bit("true after reset", 1'b0, cond_true_o);
		chk_bit("hresp okay", 1'b0, hresp_o);
		// Field widths at their upper bounds; the constant at its most negative value.
		wr(`COE_A_SRC1, 32'hffff_ff06);
		rd_chk(`COE_A_SRC1, 32'h000f_ff06, "src1 fields");
		wr(`COE_A_SRC2, 32'hffff_ff0f);
		rd_chk(`COE_A_SRC2, 32'h000f_ff0f, "src2 fields");
		wr(`COE_A_TIMER, 32'd1000);
		rd_chk(`COE_A_TIMER, 32'h0000_03e8, "timer max");
		wr(`COE_A_COUNT, 32'd10000);
		rd_chk(`COE_A_COUNT, 32'h0000_2710, "count max");
		wr(`COE_A_CONST, 32'h8000_0000);
		rd_chk(`COE_A_CONST, 32'h8000_0000, "const min");
		// Bit tests: operand one bit is set, operand two bit is clear.
		wr(`COE_A_SRC1, 32'h0003_0502);
		wr(`COE_A_SRC2, 32'h000f_0004);
		for (int c = 0; c < 4; c++) begin
			eval(c[3:0], res, n);
			chk_bit("bit cond", 1'(4'b1001 >> c), res);
		end
		// Offset 255 with bit 15 set, then its clear neighbour bit 14.
		wr(`COE_A_SRC1, 32'h000f_ff05);
		eval(`COE_C_ON, res, n);
		chk_bit("bit 15 at offset 255", 1'b1, res);
		wr(`COE_A_SRC1, 32'h000e_ff05);
		eval(`COE_C_ON, res, n);
		chk_bit("bit 14 at offset 255", 1'b0, res);
		// Signed relations: memory against constant, memory against memory, constant first.
		wr(`COE_A_CONST, 32'h0000_0001);
		s1 = '{32'h0000_0a01, 32'h0000_0a01, 32'h0000_000f};
		s2 = '{32'h0000_000f, 32'h0000_ff03, 32'h0000_0a01};
		av = '{32'hffff_ffff, 32'hffff_ffff, 32'h0000_0001};
		bv = '{32'h0000_0001, 32'h8000_0000, 32'hffff_ffff};
		for (int p = 0; p < 3; p++) begin
			wr(`COE_A_SRC1, s1[p]);
			wr(`COE_A_SRC2, s2[p]);
			for (int c = 4; c < 10; c++) begin
				eval(c[3:0], res, n);
				chk_bit("data cond", rel(c[3:0], av[p], bv[p]), res);
			end
		end
		// A wait of three ticks must not end early.
		wr(`COE_A_TIMER, 32'd3);
		eval(`COE_C_TIMER, res, n);
		chk_bit("timer result", 1'b1, res);
		chk_bit("timer wait", 1'b1, n >= 3 * TICK && n <= 3 * TICK + 2);
		// A count of two gives true, false and reload, then the same again.
		wr(`COE_A_COUNT, 32'd2);
		for (int i = 0; i < 4; i++) begin
			eval(`COE_C_COUNT, res, n);
			chk_bit("counter", ~i[0], res);
		end
		rd_chk(`COE_A_STAT, 32'h0002_0002, "stat after reload");
		// Refused settings end with the error flag and a false result.
		wr(`COE_A_SRC1, 32'h0000_000f);
		// Status shows done and error; the remaining count is 2 until the count write reloads it.
		// The last case is an undefined condition code, refused by itself.
		ea = '{`COE_A_SRC2, `COE_A_SRC1, `COE_A_TIMER, `COE_A_COUNT, `COE_A_CONST};
		evl = '{32'h0000_000f, 32'h0000_0007, 32'd1001, 32'd10001, 32'h0000_0000};
		ec = '{`COE_C_EQ, `COE_C_ON, `COE_C_TIMER, `COE_C_COUNT, 4'hc};
		evs = '{32'h0002_000a, 32'h0002_000a, 32'h0002_000a, 32'h2711_000a, 32'h2711_000a};
		for (int e = 0; e < 5; e++) begin
			wr(ea[e], evl[e]);
			eval(ec[e], res, n);
			chk_bit("refused result", 1'b0, res);
			rd_chk(`COE_A_STAT, evs[e], "refused stat");
		end
		close_out();
	end
endmodule // tb
